// [rtl/agtc_defines.svh]
// Constants for the channel 10 angle timer control and status block
// Assumes inclusion by bare name from rtl/ sources
`ifndef AGTC_DEFINES_SVH
`define AGTC_DEFINES_SVH

// ----------------------------------------
// Register offsets (word index on plain port)
// ----------------------------------------
`define AGTC_OFS_CTRL   4'h0
`define AGTC_OFS_STAT   4'h1
`define AGTC_OFS_IEN    4'h2
`define AGTC_OFS_NFLIM  4'h3
`define AGTC_OFS_STBY   4'h4

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define AGTC_CTL_CLR2B  7
`define AGTC_CTL_CLR1B  6
`define AGTC_CTL_CLR2A  5
`define AGTC_CTL_CLR1A  4
`define AGTC_CTL_CAPD   3
`define AGTC_CTL_NFEN   2
`define AGTC_CTL_EDGE_HI 1
`define AGTC_CTL_EDGE_LO 0

// ----------------------------------------
// Status field positions and widths
// ----------------------------------------
`define AGTC_ST_MG      3
`define AGTC_ST_MB      2
`define AGTC_ST_CA      1
`define AGTC_ST_MA      0
`define AGTC_NFLAGS     4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AGTC_CTRL_RST   8'h00
`define AGTC_STAT_RST   4'h0
`define AGTC_IEN_RST    4'h0
`define AGTC_NFLIM_RST  8'hff
`define AGTC_NFCNT_RST  8'h00

`endif

// [rtl/agtc_pkg.sv]
// Types shared by the channel 10 angle timer control and status block
// Assumes the defines header is on the include path
package agtc_pkg;
  // Edge select encoding
  typedef enum logic [1:0]
  {
    AGTC_EDGE_OFF  = 2'b00,
    AGTC_EDGE_RISE = 2'b01,
    AGTC_EDGE_FALL = 2'b10,
    AGTC_EDGE_BOTH = 2'b11
  } agtc_edge_t;

  // Noise filter state
  typedef enum logic [0:0]
  {
    AGTC_NF_OPEN = 1'b0,
    AGTC_NF_MASK = 1'b1
  } agtc_nf_state_t;
endpackage

// [rtl/agtc_sync.sv]
// Three-stage synchroniser with agreement of stages two and three
// Assumes a single clock domain and active-low async reset
`timescale 1ns/1ns
`default_nettype none
module agtc_sync
(
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output var  logic level_o
);
  logic [2:0] stage_reg;

  // Shift chain; first stage read only by the second
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stage_reg <= 3'h0;
    else
      stage_reg <= {stage_reg[1:0], async_i};
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      level_o <= 1'b0;
    else if (stage_reg[1] == stage_reg[2])
      level_o <= stage_reg[2];
  end
endmodule
`default_nettype wire

// [rtl/agtc_noise_filter.sv]
// Noise filter: masks input after an accepted edge until count reaches limit
// Assumes input already synchronised to core_clk_i
`timescale 1ns/1ns
`default_nettype none
`include "agtc_defines.svh"
module agtc_noise_filter
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       clr_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] limit_i,
  input  wire logic       in_i,
  output var  logic       out_o,
  output var  logic [7:0] count_o
);
  import agtc_pkg::*;
  agtc_nf_state_t state_reg;

  // Mask window: hold output, count until limit, then release
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= AGTC_NF_OPEN;
      out_o     <= 1'b0;
      count_o   <= `AGTC_NFCNT_RST;
    end
    else if (clr_i)
    begin
      state_reg <= AGTC_NF_OPEN;
      out_o     <= 1'b0;
      count_o   <= `AGTC_NFCNT_RST;
    end
    else if (!enable_i)
    begin
      state_reg <= AGTC_NF_OPEN;
      out_o     <= in_i;
      count_o   <= `AGTC_NFCNT_RST;
    end
    else
    begin
      unique case (state_reg)
        AGTC_NF_OPEN:
          if (in_i != out_o)
          begin
            out_o     <= in_i;
            count_o   <= `AGTC_NFCNT_RST;
            state_reg <= AGTC_NF_MASK;
          end
        AGTC_NF_MASK:
          if (count_o == limit_i)
            state_reg <= AGTC_NF_OPEN;
          else
            count_o <= count_o + 8'h01;
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/agtc_top.sv]
// Channel 10 angle timer control and status registers with event logic
// Assumes a plain register port, one clock, async active-low reset
//
// Function
// - Ctrl bits 7/5 clear channel 2 counter B/A on correction clear match.
// - Ctrl bits 6/4 clear channel 1 counter B/A on correction clear match.
// - Ctrl bit 3 allows capture D requests on event counter B match.
// - Ctrl bit 2 enables the input noise filter, else bypass.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both; reset 00.
// - Angle clock pulses on each selected edge of the external input.
// - Each set flag requests an interrupt when its enable bit is one.
// - Status register zero on reset and in standby.
// - Status bits 15..4 read zero; software writes zero there.
// - Outside reset and standby, a flag clears only by writing zero after reading it as one.
// - Bit 3 sets when counter G equals general register G.
// - Bit 2 sets when event counter B increments while equal to compare B.
// - Bit 1 sets when counter A is captured into capture register A.
// - Bit 0 sets when counter A equals compare register A.
// - Control register zero on reset and in standby.
// - Filter masks input after edge until its counter reaches the limit.
// - Per-flag interrupt enables gate requests; reset disabled.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "agtc_defines.svh"
module agtc_top
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [15:0] reg_rdata_o,
  // Standby modes
  input  wire logic        hw_standby_i,
  // Pin and counter compare events
  input  wire logic        angle_ext_input_i,
  input  wire logic        correction_match_i,
  input  wire logic        event_counter_b_match_i,
  input  wire logic        event_counter_b_inc_i,
  input  wire logic        counter_g_match_i,
  input  wire logic        capture_a_i,
  input  wire logic        counter_a_match_i,
  // Outputs to the rest of the timer
  output var  logic        angle_clock_o,
  output var  logic        clear_ch1_ctr_a_o,
  output var  logic        clear_ch1_ctr_b_o,
  output var  logic        clear_ch2_ctr_a_o,
  output var  logic        clear_ch2_ctr_b_o,
  output var  logic        capture_d_request_o,
  output var  logic [3:0]  irq_req_o,
  output logic             irq_o
);
  import agtc_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  ctrl_reg;
  logic [3:0]  stat_reg;
  logic [3:0]  ien_reg;
  logic [7:0]  nflim_reg;
  logic        sw_standby_reg;
  logic [3:0]  armed_reg;
  logic [3:0]  set_next;
  logic        standby;
  logic        in_sync;
  logic        in_filt;
  logic        filt_prev_reg;
  logic [7:0]  nf_count;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        rd_stat;
  agtc_edge_t  edge_sel;

  assign standby  = hw_standby_i | sw_standby_reg;
  assign wr_ctrl  = reg_wr_i && (reg_addr_i == `AGTC_OFS_CTRL);
  assign wr_stat  = reg_wr_i && (reg_addr_i == `AGTC_OFS_STAT);
  assign rd_stat  = reg_rd_i && (reg_addr_i == `AGTC_OFS_STAT);
  assign edge_sel = agtc_edge_t'(ctrl_reg[`AGTC_CTL_EDGE_HI:`AGTC_CTL_EDGE_LO]);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Standby forces reset value; writes ignored meanwhile
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ctrl_reg <= `AGTC_CTRL_RST;
    else if (standby)
      ctrl_reg <= `AGTC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= reg_wdata_i[7:0];
  end

  // Interrupt enables and filter limit
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ien_reg   <= `AGTC_IEN_RST;
      nflim_reg <= `AGTC_NFLIM_RST;
    end
    else if (standby)
    begin
      ien_reg   <= `AGTC_IEN_RST;
      nflim_reg <= `AGTC_NFLIM_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `AGTC_OFS_IEN)
        ien_reg <= reg_wdata_i[3:0];
      if (reg_addr_i == `AGTC_OFS_NFLIM)
        nflim_reg <= reg_wdata_i[7:0];
    end
  end

  // Software standby bit; it stays writable so software can leave standby
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sw_standby_reg <= 1'b0;
    else if (reg_wr_i && (reg_addr_i == `AGTC_OFS_STBY))
      sw_standby_reg <= reg_wdata_i[0];
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Hardware set conditions
  always_comb
  begin
    set_next = 4'h0;
    set_next[`AGTC_ST_MG] = counter_g_match_i;
    set_next[`AGTC_ST_MB] = event_counter_b_inc_i && event_counter_b_match_i;
    set_next[`AGTC_ST_CA] = capture_a_i;
    set_next[`AGTC_ST_MA] = counter_a_match_i;
  end

  // Per-flag read-arm, clear-by-zero, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `AGTC_NFLAGS; gi = gi + 1)
    begin : g_flag
      // Arm remembers a read that saw the flag at one
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          armed_reg[gi] <= 1'b0;
        else if (standby)
          armed_reg[gi] <= 1'b0;
        else if (rd_stat && stat_reg[gi])
          armed_reg[gi] <= 1'b1;
        else if (wr_stat || !stat_reg[gi])
          armed_reg[gi] <= 1'b0;
      end

      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          stat_reg[gi] <= 1'b0;
        else if (standby)
          stat_reg[gi] <= 1'b0;
        else if (set_next[gi])
          stat_reg[gi] <= 1'b1;
        else if (wr_stat && armed_reg[gi] && !reg_wdata_i[gi])
          stat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `AGTC_OFS_CTRL:  reg_rdata_o <= {8'h00, ctrl_reg};
        `AGTC_OFS_STAT:  reg_rdata_o <= {12'h000, stat_reg};
        `AGTC_OFS_IEN:   reg_rdata_o <= {12'h000, ien_reg};
        `AGTC_OFS_NFLIM: reg_rdata_o <= {8'h00, nflim_reg};
        `AGTC_OFS_STBY:  reg_rdata_o <= {15'h0000, sw_standby_reg};
        default:         reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

  // ----------------------------------------
  // External input path
  // ----------------------------------------
  agtc_sync u_sync
  (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    (angle_ext_input_i),
    .level_o    (in_sync)
  );

  // Filter is bypassed inside when its enable is low
  agtc_noise_filter u_filt
  (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (standby),
    .enable_i   (ctrl_reg[`AGTC_CTL_NFEN]),
    .limit_i    (nflim_reg),
    .in_i       (in_sync),
    .out_o      (in_filt),
    .count_o    (nf_count)
  );

  // Edge detection; history tracked even while disabled to avoid false edge
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      filt_prev_reg <= 1'b0;
    else
      filt_prev_reg <= in_filt;
  end

  // Angle clock pulse from the selected edges
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      angle_clock_o <= 1'b0;
    else
    begin
      unique case (edge_sel)
        AGTC_EDGE_OFF:  angle_clock_o <= 1'b0;
        AGTC_EDGE_RISE: angle_clock_o <= in_filt & ~filt_prev_reg;
        AGTC_EDGE_FALL: angle_clock_o <= ~in_filt & filt_prev_reg;
        AGTC_EDGE_BOTH: angle_clock_o <= in_filt ^ filt_prev_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Counter clear and capture requests
  // ----------------------------------------
  // Registered pulses; counters must already run on the corrected clock
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clear_ch2_ctr_b_o   <= 1'b0;
      clear_ch1_ctr_b_o   <= 1'b0;
      clear_ch2_ctr_a_o   <= 1'b0;
      clear_ch1_ctr_a_o   <= 1'b0;
      capture_d_request_o <= 1'b0;
    end
    else
    begin
      clear_ch2_ctr_b_o   <= correction_match_i & ctrl_reg[`AGTC_CTL_CLR2B];
      clear_ch1_ctr_b_o   <= correction_match_i & ctrl_reg[`AGTC_CTL_CLR1B];
      clear_ch2_ctr_a_o   <= correction_match_i & ctrl_reg[`AGTC_CTL_CLR2A];
      clear_ch1_ctr_a_o   <= correction_match_i & ctrl_reg[`AGTC_CTL_CLR1A];
      capture_d_request_o <= event_counter_b_match_i & ctrl_reg[`AGTC_CTL_CAPD];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_req_o <= 4'h0;
    else
      irq_req_o <= stat_reg & ien_reg;
  end

  assign irq_o = |(stat_reg & ien_reg);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_read_one(int b);
    rd_stat && stat_reg[b] && !set_next[b];
  endsequence

  // Read, one quiet cycle, then the zero write, as a plain master issues them
  AST_CLEAR_SEQ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_read_one(0) ##1 (!wr_stat && !standby)
      ##1 (wr_stat && !reg_wdata_i[0] && !set_next[0] && !standby))
      |=> !stat_reg[0])
    else $error("flag 0 not cleared after read then zero write");
  AST_WRITE_ONE_KEEPS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (stat_reg[1] && wr_stat && reg_wdata_i[1] && !standby) |=> stat_reg[1])
    else $error("writing one cleared flag 1");
  AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (set_next[1] && wr_stat && !standby) |=> stat_reg[1])
    else $error("set lost against clear");
  AST_MATCH_G: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (counter_g_match_i && !standby) |=> stat_reg[3])
    else $error("match g flag not set");
  AST_STBY_ZERO: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    hw_standby_i |=> (stat_reg == `AGTC_STAT_RST) && (ctrl_reg == `AGTC_CTRL_RST))
    else $error("standby did not clear registers");
  AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[15:4] == 12'h000)
    else $error("reserved status bits read nonzero");
  AST_CLEAR_1A: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (correction_match_i && ctrl_reg[`AGTC_CTL_CLR1A]) |=> clear_ch1_ctr_a_o)
    else $error("ch1 counter a clear missing");
  AST_CLEAR_2B_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !ctrl_reg[`AGTC_CTL_CLR2B] |=> !clear_ch2_ctr_b_o)
    else $error("ch2 counter b cleared while disabled");
  AST_CAPD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(capture_d_request_o) |-> $past(ctrl_reg[`AGTC_CTL_CAPD]) && $past(event_counter_b_match_i))
    else $error("capture d request without cause");
  AST_IRQ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    irq_o == |(stat_reg & ien_reg))
    else $error("interrupt does not follow flags");
  AST_EDGE_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (edge_sel == AGTC_EDGE_OFF) |=> !angle_clock_o)
    else $error("angle clock while input disabled");
  AST_RISE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (edge_sel == AGTC_EDGE_RISE && in_filt && !filt_prev_reg) |=> angle_clock_o)
    else $error("rising edge missed");
  // Filter counter restarts on every change it lets through
  AST_NF_COUNT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (in_filt != filt_prev_reg) |-> (nf_count == `AGTC_NFCNT_RST))
    else $error("filter counter not restarted at accepted edge");
  AST_NF_HOLD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ((in_filt != filt_prev_reg) && $past(ctrl_reg[`AGTC_CTL_NFEN]) && !$past(standby)
      && ctrl_reg[`AGTC_CTL_NFEN] && !standby && (nflim_reg != 8'h00)) |=> $stable(in_filt))
    else $error("filter output moved inside the mask window");
endmodule
`default_nettype wire

// [bench/agtc_test.sv]
// Self-checking bench for the channel 10 angle timer control and status block
// Assumes agtc_top, agtc_pkg and agtc_defines.svh are compiled ahead of it
`timescale 1ns/1ns
`default_nettype none
`include "agtc_defines.svh"
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module agtc_test;
  import agtc_pkg::*;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        hw_sb   = 1'b0;
  logic        pin     = 1'b0;
  logic        corr    = 1'b0;
  logic        evb_m   = 1'b0;
  logic        evb_inc = 1'b0;
  logic        g_m     = 1'b0;
  logic        cap_a   = 1'b0;
  logic        a_m     = 1'b0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic        ac;
  logic        clr1a;
  logic        clr1b;
  logic        clr2a;
  logic        clr2b;
  logic        capd;
  logic [3:0]  irq_req;
  logic        irq;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          ac_cnt    = 0;

  agtc_top uut
  (
    .core_clk_i              (clk),
    .arst_n_i                (rst_n),
    .reg_addr_i              (addr),
    .reg_wdata_i             (wdata),
    .reg_wr_i                (wr),
    .reg_rd_i                (rd),
    .reg_rdata_o             (rdata),
    .hw_standby_i            (hw_sb),
    .angle_ext_input_i       (pin),
    .correction_match_i      (corr),
    .event_counter_b_match_i (evb_m),
    .event_counter_b_inc_i   (evb_inc),
    .counter_g_match_i       (g_m),
    .capture_a_i             (cap_a),
    .counter_a_match_i       (a_m),
    .angle_clock_o           (ac),
    .clear_ch1_ctr_a_o       (clr1a),
    .clear_ch1_ctr_b_o       (clr1b),
    .clear_ch2_ctr_a_o       (clr2a),
    .clear_ch2_ctr_b_o       (clr2b),
    .capture_d_request_o     (capd),
    .irq_req_o               (irq_req),
    .irq_o                   (irq)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // Angle clock pulse tally; tests compare differences, never reset it
  always @(posedge clk)
    if (ac === 1'b1)
      ac_cnt <= ac_cnt + 1;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Bus and event helpers
  // ----------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle events: bit 3 G match, 2 B match with increment, 1 capture A, 0 A match
  task automatic fire(input logic [3:0] f);
    @(posedge clk);
    g_m     <= f[3];
    evb_m   <= f[2];
    evb_inc <= f[2];
    cap_a   <= f[1];
    a_m     <= f[0];
    @(posedge clk);
    {g_m, evb_m, evb_inc, cap_a, a_m} <= 5'h00;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl reset", 16'h0000, d)
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("status reset", 16'h0000, d)
    rd_reg(`AGTC_OFS_IEN, d);
    `CHK("enable reset", 16'h0000, d)
    rd_reg(`AGTC_OFS_NFLIM, d);
    `CHK("limit reset", 16'h00ff, d)
    rd_reg(4'h9, d);
    `CHK("unmapped read", 16'h0000, d)
    `CHK("irq reset", 1'b0, irq)
    $display("test reset values done");
  endtask

  // Each enable bit alone, bit 2 as the no-clear case
  task automatic t_clear();
    logic [4:0] o;
    // Counters are taken to run on the corrected angle clock before clears are enabled
    wr_reg(`AGTC_OFS_CTRL, 16'h00a5);
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl readback", 16'h00a5, d)
    for (int b = 2; b < 8; b++)
    begin
      wr_reg(`AGTC_OFS_CTRL, 16'(1 << b));
      @(posedge clk);
      corr  <= 1'b1;
      evb_m <= 1'b1;
      @(posedge clk);
      corr  <= 1'b0;
      evb_m <= 1'b0;
      #1 o = {clr2b, clr1b, clr2a, clr1a, capd};
      `CHK("clear outputs", 5'(b > 2 ? 1 << (b - 3) : 0), o)
    end
    // Match without increment must not set the B flag
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("no B flag", 16'h0000, d)
    $display("test clear enables done");
  endtask

  task automatic t_edge();
    int c;
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(`AGTC_OFS_CTRL, 16'(m));
      idle(10);
      c = ac_cnt;
      pin <= 1'b1;
      idle(12);
      `CHK("rise pulses", m & 1, ac_cnt - c)
      c = ac_cnt;
      pin <= 1'b0;
      idle(12);
      `CHK("fall pulses", (m >> 1) & 1, ac_cnt - c)
    end
    $display("test edge select done");
  endtask

  // Glitch inside the mask window: three pulses bypassed, one filtered
  task automatic t_filter();
    int c;
    wr_reg(`AGTC_OFS_NFLIM, 16'h0014);
    for (int en = 0; en < 2; en++)
    begin
      wr_reg(`AGTC_OFS_CTRL, 16'(3 + 4 * en));
      idle(30);
      c = ac_cnt;
      pin <= 1'b1;
      idle(2);
      pin <= 1'b0;
      idle(4);
      pin <= 1'b1;
      idle(40);
      `CHK("glitch pulses", (en == 1) ? 1 : 3, ac_cnt - c)
      pin <= 1'b0;
      idle(40);
    end
    $display("test noise filter done");
  endtask

  task automatic t_flags();
    wr_reg(`AGTC_OFS_CTRL, 16'h0000);
    for (int f = 0; f < 4; f++)
    begin
      wr_reg(`AGTC_OFS_IEN, 16'h0000);
      fire(4'(1 << f));
      idle(2);
      `CHK("irq masked", 1'b0, irq)
      rd_reg(`AGTC_OFS_STAT, d);
      `CHK("flag set", 16'(1 << f), d)
      wr_reg(`AGTC_OFS_IEN, 16'(1 << f));
      idle(2);
      `CHK("irq line", 1'b1, irq)
      `CHK("irq request", 4'(1 << f), irq_req)
      wr_reg(`AGTC_OFS_STAT, 16'h0000);
      idle(2);
      `CHK("irq cleared", 1'b0, irq)
    end
    $display("test flags and interrupts done");
  endtask

  task automatic t_clrseq();
    fire(4'b1111);
    // Write of zero without a prior read has no effect
    wr_reg(`AGTC_OFS_STAT, 16'h0000);
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("unread clear", 16'h000f, d)
    // Ones only on the flag bits; reserved bits get zero
    wr_reg(`AGTC_OFS_STAT, 16'h000f);
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("write ones", 16'h000f, d)
    wr_reg(`AGTC_OFS_STAT, 16'h000a);
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("partial clear", 16'h000a, d)
    // Capture event in the same cycle as the clearing write
    @(posedge clk);
    addr  <= `AGTC_OFS_STAT;
    wdata <= 16'h0000;
    wr    <= 1'b1;
    cap_a <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    cap_a <= 1'b0;
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("set wins", 16'h0002, d)
    wr_reg(`AGTC_OFS_STAT, 16'h0000);
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("all cleared", 16'h0000, d)
    $display("test clear sequence done");
  endtask

  task automatic t_standby();
    wr_reg(`AGTC_OFS_CTRL, 16'h00ff);
    wr_reg(`AGTC_OFS_IEN, 16'h000f);
    fire(4'b0001);
    @(posedge clk);
    hw_sb <= 1'b1;
    idle(2);
    `CHK("irq standby", 1'b0, irq)
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl hw standby", 16'h0000, d)
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("status hw standby", 16'h0000, d)
    rd_reg(`AGTC_OFS_IEN, d);
    `CHK("enable hw standby", 16'h0000, d)
    wr_reg(`AGTC_OFS_CTRL, 16'h0003);
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl write refused", 16'h0000, d)
    @(posedge clk);
    hw_sb <= 1'b0;
    wr_reg(`AGTC_OFS_CTRL, 16'h00ff);
    fire(4'b0001);
    wr_reg(`AGTC_OFS_STBY, 16'h0001);
    idle(2);
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl sw standby", 16'h0000, d)
    rd_reg(`AGTC_OFS_STAT, d);
    `CHK("status sw standby", 16'h0000, d)
    wr_reg(`AGTC_OFS_STBY, 16'h0000);
    wr_reg(`AGTC_OFS_CTRL, 16'h0003);
    rd_reg(`AGTC_OFS_CTRL, d);
    `CHK("ctrl after standby", 16'h0003, d)
    $display("test standby done");
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence after a four-cycle reset
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_clear();
    t_edge();
    t_filter();
    t_flags();
    t_clrseq();
    t_standby();
    summarize();
  end
endmodule
`default_nettype wire
